// File: design/pwi_dev_end.sv
// device end: wiper setting slave on the two-wire bus
`timescale 1ns/1ps
`include "pwi_cfg.svh"
// Notes on behaviour
// RULE1: master starts transfers only on idle bus
// RULE2: sda change while scl high is start/stop
// RULE3: master owns scl; device only slave
// RULE4: sda fall with scl high is start
// RULE5: sda rise with scl high is stop
// RULE6: receiver pulls sda low on ninth clock
// RULE7: matching address byte gets an acknowledge
// RULE8: every written byte is acknowledged
// RULE9: read: send eight bits, sample ack
// RULE10: no ack ends sending until stop
// RULE11: pulses up to 50 ns are filtered
// RULE12: master waits 1 ms after power-up
// RULE13: wiper moves 5 to 10 us after write
// RULE14: wiper settles 5 to 10 us after power
// RULE15: write is address, 00h, data, stop
// RULE16: read uses repeated start, master nacks
// RULE17: wiper keeps seven bits, msb reads zero
// RULE18: wiper setting starts at midscale 40h
// RULE19: sda open drain; stop returns to idle
// RULE20: foreign address ignored until next start
module pwi_dev_end
   import pwi_pkg::*;
(
   input  wire logic       linkClk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   pwi_if.dev              bus,
   output      logic [6:0] wiperPos,
   output      logic       wiperSettled
);
   // ***********************************
   // state and reset value
   // ***********************************
   localparam pwi_dev_state_t DEV_RST = '{
      st: PWI_D_IDLE, sclD: 1'b1, sdaD: 1'b1, cnt: 4'h0, shf: 8'h00,
      rd: 1'b0, regOk: 1'b0, ackSeen: 1'b0, sdaOe_n: 1'b1, sdaOut: 1'b0,
      wiper_setting_register: `PWI_WIPER_MID, wiperPos: `PWI_WIPER_MID, settled: 1'b0,
      settle: 8'(`PWI_SETTLE_SUP_CYC)};
   pwi_dev_state_t r;       // registered state
   pwi_dev_state_t n;       // next state
   logic           sclF;    // filtered clock line
   logic           sdaF;    // filtered data line
   logic           sclRise; // clock edge, data sampled
   logic           sclFall; // clock edge, data changes
   logic           startC;  // start condition seen
   logic           stopC;   // stop condition seen
   logic           byteEnd; // eighth bit done, clock fell
   // ***********************************
   // pin conditioning
   // ***********************************
   // short pulses on either line never reach the engine, see RULE11
   pwi_pin_filter uSclFilt (
      .clk   (linkClk),
      .rst_n (rst_n),
      .ce    (ce),
      .pin   (bus.scl),
      .q     (sclF)
   );
   pwi_pin_filter uSdaFilt (
      .clk   (linkClk),
      .rst_n (rst_n),
      .ce    (ce),
      .pin   (bus.sda),
      .q     (sdaF)
   );
   // ***********************************
   // bus events
   // ***********************************
   // edges taken from filtered lines, so glitches make no events
   assign sclRise = sclF & ~r.sclD;
   assign sclFall = ~sclF & r.sclD;
   assign startC  = sclF & r.sclD & r.sdaD & ~sdaF;   // see RULE4
   assign stopC   = sclF & r.sclD & ~r.sdaD & sdaF;   // see RULE5
   assign byteEnd = sclFall && (r.cnt == `PWI_BYTE_BITS);
   // ***********************************
   // protocol engine
   // ***********************************
   // start and stop win over any bit activity in the same cycle
   always_comb
   begin
      n        = r;
      n.sclD   = sclF;
      n.sdaD   = sdaF;
      n.sdaOut = 1'b0;                  // only ever pulls low, see RULE19
      // settle timer: visible position follows the setting late
      if (r.settle != 8'h00)
      begin
         n.settle = r.settle - 8'h01;
         if (r.settle == 8'h01)
         begin
            n.wiperPos = r.wiper_setting_register;         // see RULE13
            n.settled  = 1'b1;          // see RULE14
         end
      end
      if (stopC)
      begin
         n.st      = PWI_D_IDLE;        // see RULE19
         n.sdaOe_n = 1'b1;
      end
      else if (startC)
      begin
         n.st      = PWI_D_ADDR;        // also repeated start, see RULE16
         n.cnt     = 4'h0;
         n.sdaOe_n = 1'b1;
      end
      else
      begin
         case (r.st)
            PWI_D_IDLE:
            begin
               // silent until a start, see RULE4
            end
            PWI_D_ADDR, PWI_D_REG, PWI_D_DATA:
            begin
               if (sclRise)
               begin
                  // data only read while clock high, see RULE2
                  n.shf = {r.shf[6:0], sdaF};
                  n.cnt = r.cnt + 4'h1;
               end
               else if (byteEnd)
               begin
                  n.cnt = 4'h0;
                  if (r.st == PWI_D_ADDR)
                  begin
                     if (r.shf[7:1] == `PWI_DEV_ID)
                     begin
                        n.st      = PWI_D_ACKA;   // see RULE7
                        n.sdaOe_n = 1'b0;         // see RULE6
                        n.rd      = r.shf[0];
                     end
                     else
                     begin
                        n.st = PWI_D_WAIT;        // see RULE20
                     end
                  end
                  else if (r.st == PWI_D_REG)
                  begin
                     n.st      = PWI_D_ACKR;      // see RULE8
                     n.sdaOe_n = 1'b0;
                     n.regOk   = (r.shf == `PWI_REG_ADDR);
                  end
                  else
                  begin
                     n.st      = PWI_D_ACKD;      // see RULE8
                     n.sdaOe_n = 1'b0;
                     // third byte lands, msb dropped, see RULE15
                     if (r.regOk)
                     begin
                        n.wiper_setting_register     = r.shf[6:0];   // see RULE17
                        n.settled = 1'b0;
                        n.settle  = 8'(`PWI_SETTLE_CMD_CYC);
                     end
                  end
               end
            end
            PWI_D_ACKA:
            begin
               if (sclFall)
               begin
                  n.cnt = 4'h0;
                  if (r.rd)
                  begin
                     // msb always zero, so the first bit pulls low
                     n.st      = PWI_D_TX;        // see RULE9
                     n.shf     = {1'b0, r.wiper_setting_register};   // see RULE17
                     n.sdaOe_n = 1'b0;
                  end
                  else
                  begin
                     n.st      = PWI_D_REG;
                     n.sdaOe_n = 1'b1;
                  end
               end
            end
            PWI_D_ACKR, PWI_D_ACKD:
            begin
               if (sclFall)
               begin
                  n.st      = PWI_D_DATA;         // more bytes still acked
                  n.sdaOe_n = 1'b1;
               end
            end
            PWI_D_TX:
            begin
               if (sclRise)
               begin
                  n.cnt = r.cnt + 4'h1;
               end
               else if (byteEnd)
               begin
                  n.st      = PWI_D_RXACK;        // release for ack, see RULE9
                  n.sdaOe_n = 1'b1;
                  n.ackSeen = 1'b0;
               end
               else if (sclFall)
               begin
                  n.shf     = {r.shf[6:0], 1'b0};
                  n.sdaOe_n = r.shf[6];           // high bit means release
               end
            end
            PWI_D_RXACK:
            begin
               if (sclRise)
               begin
                  n.ackSeen = ~sdaF;
               end
               else if (sclFall)
               begin
                  n.cnt = 4'h0;
                  if (r.ackSeen)
                  begin
                     n.st      = PWI_D_TX;        // see RULE9
                     n.shf     = {1'b0, r.wiper_setting_register};
                     n.sdaOe_n = 1'b0;
                  end
                  else
                  begin
                     n.st = PWI_D_WAIT;           // see RULE10
                  end
               end
            end
            PWI_D_WAIT:
            begin
               // line released; only start or stop leaves here
            end
            default:
            begin
               n.st      = PWI_D_IDLE;
               n.sdaOe_n = 1'b1;
            end
         endcase
      end
   end
   // ***********************************
   // state register
   // ***********************************
   // reset loads midscale and arms the power-up settle timer
   always_ff @(posedge linkClk)
   begin
      if (!rst_n)
         r <= DEV_RST;                  // see RULE18
      else if (ce)
         r <= n;
   end
   // ***********************************
   // outputs, all straight from flops
   // ***********************************
   assign bus.sdaDevOut  = r.sdaOut;
   assign bus.sdaDevOe_n = r.sdaOe_n;
   assign wiperPos       = r.wiperPos;
   assign wiperSettled   = r.settled;
endmodule : pwi_dev_end

// File: include/pwi_cfg.svh
// constants for the potentiometer wiper two-wire link
`ifndef PWI_CFG_SVH
`define PWI_CFG_SVH
// ***********************************
// clock rates
// ***********************************
`define PWI_CLK_PERIOD_NS   50
`define PWI_LINK_PERIOD_NS  64
// ***********************************
// timing, in ns and in cycles
// ***********************************
// glitch_filter_time: longest pulse that is suppressed
`define PWI_GLITCH_NS       50
`define PWI_GLITCH_CYC      ((`PWI_GLITCH_NS+`PWI_LINK_PERIOD_NS-1)/`PWI_LINK_PERIOD_NS)
// wiper_settle_after_command, least time
`define PWI_SETTLE_CMD_NS   5000
`define PWI_SETTLE_CMD_CYC  ((`PWI_SETTLE_CMD_NS+`PWI_LINK_PERIOD_NS-1)/`PWI_LINK_PERIOD_NS)
// wiper_settle_after_supply, least time
`define PWI_SETTLE_SUP_NS   5000
`define PWI_SETTLE_SUP_CYC  ((`PWI_SETTLE_SUP_NS+`PWI_LINK_PERIOD_NS-1)/`PWI_LINK_PERIOD_NS)
// power_up_read_delay / power_up_write_delay, longest time
`define PWI_PWRUP_NS        1000000
`define PWI_PWRUP_CYC       (`PWI_PWRUP_NS/`PWI_CLK_PERIOD_NS)
// quarter of one bus bit on the host side
`define PWI_QTR_NS          1250
`define PWI_QTR_CYC         (`PWI_QTR_NS/`PWI_CLK_PERIOD_NS)
// ***********************************
// protocol values
// ***********************************
// device identifier: value is arbitrary
`define PWI_DEV_ID          7'h21
`define PWI_REG_ADDR        8'h00
`define PWI_WIPER_MID       7'h40
`define PWI_BYTE_BITS       4'h8
`endif

// File: include/pwi_pkg.sv
// types shared by both ends of the wiper link
package pwi_pkg;
   // device states, gray along the usual path
   typedef enum logic [3:0] {
      PWI_D_IDLE  = 4'h0,
      PWI_D_ADDR  = 4'h1,
      PWI_D_ACKA  = 4'h3,
      PWI_D_REG   = 4'h2,
      PWI_D_ACKR  = 4'h6,
      PWI_D_DATA  = 4'h7,
      PWI_D_ACKD  = 4'h5,
      PWI_D_TX    = 4'h4,
      PWI_D_RXACK = 4'hC,
      PWI_D_WAIT  = 4'hD
   } pwi_dev_st_t;
   typedef struct packed {
      pwi_dev_st_t st;
      logic        sclD;
      logic        sdaD;
      logic [3:0]  cnt;
      logic [7:0]  shf;
      logic        rd;
      logic        regOk;
      logic        ackSeen;
      logic        sdaOe_n;
      logic        sdaOut;
      logic [6:0]  wiper_setting_register;
      logic [6:0]  wiperPos;
      logic        settled;
      logic [7:0]  settle;
   } pwi_dev_state_t;
   // host states
   typedef enum logic [2:0] {
      PWI_H_PWR   = 3'h0,
      PWI_H_IDLE  = 3'h1,
      PWI_H_START = 3'h3,
      PWI_H_BYTE  = 3'h2,
      PWI_H_STOP  = 3'h6
   } pwi_host_st_t;
   typedef struct packed {
      pwi_host_st_t st;
      logic [15:0]  tick;
      logic [1:0]   qtr;
      logic [3:0]   bitNo;
      logic [1:0]   byteNo;
      logic         rd;
      logic [6:0]   data;
      logic [7:0]   shf;
      logic         nack;
      logic         scl;
      logic         sdaOe_n;
      logic         sdaOut;
      logic         s1;
      logic         s2;
      logic         cmdReady;
      logic         rspValid;
      logic [7:0]   rspData;
      logic         rspNack;
   } pwi_host_state_t;
   typedef struct packed {
      logic       s1;
      logic       s2;
      logic       q;
      logic [3:0] cnt;
   } pwi_filt_state_t;
endpackage : pwi_pkg

// File: include/pwi_if.sv
// two-wire bus between host end and device end
`timescale 1ns/1ps
interface pwi_if;
   logic scl;            // clock, driven only by the host
   logic sda;            // resolved data wire
   logic sdaHostOut;     // host data level when driving
   logic sdaHostOe_n;    // host drives while low
   logic sdaDevOut;      // device data level when driving
   logic sdaDevOe_n;     // device drives while low
   // wired-and with pull-up: any driver pulling low wins
   assign sda = ~((~sdaHostOe_n & ~sdaHostOut) | (~sdaDevOe_n & ~sdaDevOut));
   modport host (output scl, output sdaHostOut, output sdaHostOe_n, input sda);
   modport dev  (input scl, input sda, output sdaDevOut, output sdaDevOe_n);
endinterface : pwi_if

// File: design/pwi_pin_filter.sv
// pin synchroniser plus glitch filter for one bus line
`timescale 1ns/1ps
module pwi_pin_filter
   import pwi_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   input  wire logic pin,
   output      logic q
);
   // ***********************************
   // state
   // ***********************************
   localparam pwi_filt_state_t FILT_RST = '{s1: 1'b1, s2: 1'b1, q: 1'b1, cnt: 4'h0};
   pwi_filt_state_t r;     // registered state
   pwi_filt_state_t n;     // next state
   // ***********************************
   // filter
   // ***********************************
   // new level taken only after it held longer than the glitch time
   always_comb
   begin
      n    = r;
      n.s1 = pin;
      n.s2 = r.s1;       // first stage read here only
      if (r.s2 == r.q)
      begin
         n.cnt = 4'h0;   // agrees, nothing pending
      end
      else if (r.cnt == 4'(`PWI_GLITCH_CYC))
      begin
         n.q   = r.s2;   // see RULE11
         n.cnt = 4'h0;
      end
      else
      begin
         n.cnt = r.cnt + 4'h1;
      end
   end
   // register, frozen while ce is low
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         r <= FILT_RST;
      else if (ce)
         r <= n;
   end
   assign q = r.q;
endmodule : pwi_pin_filter

// File: design/pwi_host_end.sv
// host end: bus master that writes and reads the wiper setting
`timescale 1ns/1ps
`include "pwi_cfg.svh"
module pwi_host_end
   import pwi_pkg::*;
#(
   parameter int PWRUP_CYC = `PWI_PWRUP_CYC
)
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   pwi_if.host             bus,
   input  wire logic       cmdValid,
   input  wire logic       cmdWrite,
   input  wire logic [6:0] cmdData,
   output      logic       cmdReady,
   output      logic       rspValid,
   output      logic [7:0] rspData,
   output      logic       rspNack
);
   // ***********************************
   // state
   // ***********************************
   localparam pwi_host_state_t HOST_RST = '{
      st: PWI_H_PWR, tick: 16'h0000, qtr: 2'h0, bitNo: 4'h0, byteNo: 2'h0,
      rd: 1'b0, data: 7'h00, shf: 8'h00, nack: 1'b0, scl: 1'b1, sdaOe_n: 1'b1,
      sdaOut: 1'b0, s1: 1'b1, s2: 1'b1, cmdReady: 1'b0, rspValid: 1'b0,
      rspData: 8'h00, rspNack: 1'b0};
   pwi_host_state_t r;     // registered state
   pwi_host_state_t n;     // next state
   logic            qEnd;  // last cycle of a quarter bit
   logic            txByte;// host sends the current byte
   logic            lastB; // current byte is the last of the command
   // ***********************************
   // byte of a command by position
   // ***********************************
   function automatic logic [7:0] byteVal(input logic [1:0] no, input logic rd, input logic [6:0] d);
      case (no)
         2'h0:    byteVal = {`PWI_DEV_ID, 1'b0};
         2'h1:    byteVal = `PWI_REG_ADDR;
         // data msb is a don't-care; sent high so the device must drop it, see RULE17
         2'h2:    byteVal = rd ? {`PWI_DEV_ID, 1'b1} : {1'b1, d};
         default: byteVal = 8'hFF;      // read byte: line left released
      endcase
   endfunction : byteVal
   assign qEnd   = (r.tick == 16'(`PWI_QTR_CYC - 1));
   assign txByte = !(r.rd && (r.byteNo == 2'h3));
   assign lastB  = r.rd ? (r.byteNo == 2'h3) : (r.byteNo == 2'h2);
   // ***********************************
   // sequencer
   // ***********************************
   // each symbol is four quarters; scl from a divider of clk
   always_comb
   begin
      n          = r;
      n.rspValid = 1'b0;
      n.sdaOut   = 1'b0;
      n.s1       = bus.sda;
      n.s2       = r.s1;                // first stage read here only
      if (r.st != PWI_H_PWR && r.st != PWI_H_IDLE)
      begin
         n.tick = qEnd ? 16'h0000 : r.tick + 16'h0001;
         if (qEnd)
            n.qtr = r.qtr + 2'h1;
      end
      case (r.st)
         PWI_H_PWR:
         begin
            // hold off traffic after power-up, see RULE12
            if (r.tick == 16'(PWRUP_CYC - 1))
            begin
               n.st       = PWI_H_IDLE;
               n.tick     = 16'h0000;
               n.cmdReady = 1'b1;
            end
            else
               n.tick = r.tick + 16'h0001;
         end
         PWI_H_IDLE:
         begin
            // only master on the bus; starts only from idle, see RULE1
            if (cmdValid && r.cmdReady)
            begin
               n.st       = PWI_H_START;
               n.cmdReady = 1'b0;
               n.rd       = ~cmdWrite;
               n.data     = cmdData;
               n.byteNo   = 2'h0;
               n.nack     = 1'b0;
               n.tick     = 16'h0000;
               n.qtr      = 2'h0;
               n.sdaOe_n  = 1'b1;
            end
         end
         PWI_H_START:
         begin
            if (qEnd)
            begin
               case (r.qtr)
                  2'h0:    n.scl = 1'b1;
                  2'h1:    n.sdaOe_n = 1'b0;  // sda falls, scl high, see RULE4
                  2'h3:
                  begin
                     n.st    = PWI_H_BYTE;
                     n.scl   = 1'b0;
                     n.bitNo = 4'h0;
                     n.shf   = byteVal(r.byteNo, r.rd, r.data);
                  end
                  default: ;
               endcase
            end
         end
         PWI_H_BYTE:
         begin
            if (qEnd)
            begin
               case (r.qtr)
                  // sda only moves while scl low, see RULE2
                  2'h0:    n.sdaOe_n = (txByte && r.bitNo != `PWI_BYTE_BITS) ? r.shf[7] : 1'b1;
                  2'h1:    n.scl = 1'b1;
                  2'h3:
                  begin
                     n.scl = 1'b0;
                     if (r.bitNo != `PWI_BYTE_BITS)
                     begin
                        n.shf   = {r.shf[6:0], r.s2};
                        n.bitNo = r.bitNo + 4'h1;
                     end
                     else if (txByte && r.s2)
                     begin
                        n.nack = 1'b1;        // no ack from device, see RULE6
                        n.st   = PWI_H_STOP;
                     end
                     else if (lastB)
                     begin
                        n.st = PWI_H_STOP;    // see RULE15
                        if (r.rd)
                           n.rspData = r.shf; // answered with no ack, see RULE16
                     end
                     else if (r.rd && r.byteNo == 2'h1)
                     begin
                        n.st     = PWI_H_START;   // repeated start, see RULE16
                        n.byteNo = 2'h2;
                     end
                     else
                     begin
                        n.byteNo = r.byteNo + 2'h1;
                        n.bitNo  = 4'h0;
                        n.shf    = byteVal(r.byteNo + 2'h1, r.rd, r.data);
                     end
                  end
                  default: ;
               endcase
            end
         end
         PWI_H_STOP:
         begin
            if (qEnd)
            begin
               case (r.qtr)
                  2'h0:    n.sdaOe_n = 1'b0;
                  2'h1:    n.scl = 1'b1;
                  2'h2:    n.sdaOe_n = 1'b1;  // sda rises, scl high, see RULE5
                  2'h3:
                  begin
                     n.st       = PWI_H_IDLE;
                     n.cmdReady = 1'b1;
                     n.rspValid = 1'b1;
                     n.rspNack  = r.nack;
                  end
                  default: ;
               endcase
            end
         end
         default:
         begin
            n.st = PWI_H_IDLE;
         end
      endcase
   end
   // ***********************************
   // state register
   // ***********************************
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         r <= HOST_RST;
      else if (ce)
         r <= n;
   end
   // ***********************************
   // outputs, all straight from flops
   // ***********************************
   assign bus.scl         = r.scl;
   assign bus.sdaHostOut  = r.sdaOut;
   assign bus.sdaHostOe_n = r.sdaOe_n;
   assign cmdReady        = r.cmdReady;
   assign rspValid        = r.rspValid;
   assign rspData         = r.rspData;
   assign rspNack         = r.rspNack;
endmodule : pwi_host_end

// File: tb/pwi_asserts.sv
// bus checker for the wiper two-wire link
`timescale 1ns/1ps
module pwi_asserts
   import pwi_pkg::*;
(
   input wire logic linkClk,
   input wire logic rst_n,
   input wire logic scl,
   input wire logic sda,
   input wire logic sdaHostOut,
   input wire logic sdaHostOe_n,
   input wire logic sdaDevOut,
   input wire logic sdaDevOe_n
);
   // ***
   // helpers
   // ***
   logic sdaQ_r;    // sda one edge back
   logic started_r; // a start was seen
   // raw pins are sampled, so edges show one link cycle late
   always_ff @(posedge linkClk)
   begin
      sdaQ_r <= sda;
      if (!rst_n)
         started_r <= 1'b0;
      else if (sdaQ_r && !sda && scl)
         started_r <= 1'b1;
   end
   default clocking cb @(posedge linkClk); endclocking
   default disable iff (!rst_n);
   chk_dev_low_only: assert property (!sdaDevOe_n |-> !sdaDevOut)
      else $error("device drove high");
   chk_host_low_only: assert property (!sdaHostOe_n |-> !sdaHostOut)
      else $error("host drove high");
   chk_quiet_pre_start: assert property (!started_r |-> sdaDevOe_n)
      else $error("device spoke before start");
   chk_stop_releases: assert property (!sdaQ_r && sda && scl |-> sdaDevOe_n[*6])
      else $error("device held after stop");
   chk_stable_scl_high: assert property (scl && $past(scl) |-> $stable(sdaDevOe_n))
      else $error("device moved at clock high");
   chk_drive_after_fall: assert property ($changed(sdaDevOe_n) |-> !scl && !$past(scl, 2))
      else $error("device moved too early");
   chk_ack_low_held: assert property ($fell(sdaDevOe_n) |-> !sdaDevOe_n[*8])
      else $error("device low too short");
   chk_scl_high_len: assert property ($rose(scl) |-> scl[*8])
      else $error("clock high too short");
endmodule : pwi_asserts

// File: tb/pot_wiper_i2c_slave_tb.sv
// self-checking bench: host end and device end on one bus
`timescale 1ns/1ps
module pot_wiper_i2c_slave_tb
   import pwi_pkg::*;
;
   localparam int PWRUP = 20; // shortened power-up wait
   logic       clk;
   logic       linkClk;
   logic       rst_n;
   logic       cmdValid;
   logic       cmdWrite;
   logic [6:0] cmdData;
   logic       cmdReady;
   logic       rspValid;
   logic [7:0] rspData;
   logic       rspNack;
   logic [6:0] wiperPos;
   logic       wiperSettled;
   int         miscompares;
   int         tests_run;
   int         cyc = 0;   // hang guard
   pwi_if bus ();
   pwi_host_end #(.PWRUP_CYC(PWRUP)) i_pwi_host_end (.clk(clk), .rst_n(rst_n), .ce(1'b1), .bus(bus),
      .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdData(cmdData), .cmdReady(cmdReady),
      .rspValid(rspValid), .rspData(rspData), .rspNack(rspNack));
   pwi_dev_end i_pwi_dev_end (.linkClk(linkClk), .rst_n(rst_n), .ce(1'b1), .bus(bus),
      .wiperPos(wiperPos), .wiperSettled(wiperSettled));
   pwi_asserts i_pwi_asserts (.linkClk(linkClk), .rst_n(rst_n), .scl(bus.scl), .sda(bus.sda),
      .sdaHostOut(bus.sdaHostOut), .sdaHostOe_n(bus.sdaHostOe_n),
      .sdaDevOut(bus.sdaDevOut), .sdaDevOe_n(bus.sdaDevOe_n));
   // two unrelated clocks
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial
   begin
      linkClk = 1'b0;
      #7;
      forever #32 linkClk = ~linkClk;
   end
   // ***
   // helpers
   // ***
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // bounded wait for a level, counting negedges
   task automatic wait_lvl(ref logic s, input logic lvl, output int n);
      n = 0;
      while (s !== lvl && n < 5000)
      begin
         @(negedge clk);
         n++;
      end
   endtask : wait_lvl
   task automatic end_of_test;
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   // one command; a read expects d back with a zero msb
   task automatic do_cmd(input logic wr, input logic [6:0] d);
      int n;
      wait_lvl(cmdReady, 1'b1, n);
      cmdValid = 1'b1;
      cmdWrite = wr;
      cmdData  = d;
      @(negedge clk);
      cmdValid = 1'b0;
      if (wr)
      begin
         // settle is timed from the latch to the new position
         wait_lvl(wiperSettled, 1'b0, n);
         wait_lvl(wiperSettled, 1'b1, n);
         chk("settle", 8'h01, {7'h00, n >= 100 && n <= 200});
         chk("wiper", {1'b0, d}, {1'b0, wiperPos});
      end
      wait_lvl(rspValid, 1'b1, n);
      chk("done", 8'h01, {7'h00, rspValid});
      chk("nack", 8'h00, {7'h00, rspNack});
      if (!wr)
         chk("read", {1'b0, d}, rspData);
   endtask : do_cmd
   // ***
   // scenarios
   // ***
   task automatic t_powerup;
      int n;
      repeat (10) @(negedge clk);
      chk("ready early", 8'h00, {7'h00, cmdReady});
      wait_lvl(wiperSettled, 1'b1, n);
      chk("power settle", 8'h01, {7'h00, n >= 90 && n <= 190});
      chk("ready late", 8'h01, {7'h00, cmdReady});
      $display("test power-up done");
   endtask : t_powerup
   task automatic t_read_mid;
      do_cmd(1'b0, 7'h40);
      $display("test midscale read done");
   endtask : t_read_mid
   // write then read back at once, no gap
   task automatic t_write_read(input logic [6:0] v);
      do_cmd(1'b1, v);
      do_cmd(1'b0, v);
      $display("test write read %h done", v);
   endtask : t_write_read
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         miscompares++;
         end_of_test;
      end
   end
   initial
   begin
      rst_n = 1'b0;
      cmdValid = 1'b0;
      cmdWrite = 1'b0;
      cmdData = 7'h00;
      miscompares = 0;
      tests_run = 0;
      repeat (10) @(negedge clk);
      chk("reset wiper", 8'h40, {1'b0, wiperPos});
      chk("reset settled", 8'h00, {7'h00, wiperSettled});
      rst_n = 1'b1;
      t_powerup;
      t_read_mid;
      t_write_read(7'h7F);
      t_write_read(7'h00);
      t_write_read(7'h2A);
      end_of_test;
   end
endmodule : pot_wiper_i2c_slave_tb
